// [src/dtr_read_preamble_addr4.v]
// Double-rate read path of a serial flash: command, address, dummy, preamble, data
`timescale 1ns/1ns
`default_nettype none
`include "dtr_read_consts.vh"
module dtr_read_preamble_addr4 (
  // Clock, reset, enable
  input  wire        mclk,
  input  wire        reset_n,
  input  wire        clk_en,
  // Serial pins from the host
  input  wire        cs_n_pin,
  input  wire        sclk_pin,
  input  wire [3:0]  io_in,
  output reg  [3:0]  io_out,
  output reg  [3:0]  io_oe,
  // Configuration and status from the rest of the device
  input  wire        write_in_progress,
  input  wire        quad_enable_bit,
  input  wire        quad_command_mode,
  input  wire        wide_addr_mode,
  input  wire        extended_address_bit,
  input  wire        dummy_select_low,
  input  wire        dummy_select_high,
  input  wire        preamble_enable_bit,
  output reg         enhance_mode,
  output reg         read_active,
  output reg         read_rejected,
  // Array read port
  output reg         mem_req,
  output reg  [31:0] mem_addr,
  input  wire        mem_valid,
  input  wire [7:0]  mem_rdata
);

  localparam ST_IDLE   = 3'd0;
  localparam ST_OPCODE = 3'd1;
  localparam ST_ADDR   = 3'd2;
  localparam ST_DUMMY  = 3'd3;
  localparam ST_DATA   = 3'd4;
  localparam ST_IGNORE = 3'd5;

  // Synchronisers for the pins
  reg        cs_s1_reg, cs_s2_reg, cs_s3_reg;
  reg        sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  reg  [3:0] io_s1_reg, io_s2_reg;

  // Sequencer state
  reg  [2:0]  state_reg;
  reg  [7:0]  op_sh_reg;
  reg  [3:0]  op_cnt_reg;
  reg  [3:0]  width_reg;
  reg         quad_cmd_reg;
  reg  [5:0]  alen_reg;
  reg  [5:0]  abits_reg;
  reg  [31:0] addr_sh_reg;
  reg  [4:0]  dcnt_reg;
  reg  [4:0]  ndummy_reg;
  reg  [3:0]  ind_hi_reg;
  reg  [7:0]  dsh_reg;
  reg  [3:0]  left_reg;
  reg         fetch_en_reg;
  reg         fetch_busy_reg;
  reg         discard_reg;

  wire sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
  wire sclk_fall = ~sclk_s2_reg & sclk_s3_reg;
  wire any_edge  = sclk_rise | sclk_fall;
  wire cs_fall   = cs_s3_reg & ~cs_s2_reg;
  // Address edges start on a rise: the fall that closes the last opcode clock is not an address edge
  wire addr_edge = (state_reg == ST_ADDR) && (sclk_rise || (sclk_fall && (abits_reg != 6'h00)));

  // Opcode shifter: serial on line 0 with upper lines ignored, or nibbles in quad command mode
  wire [7:0] op_new  = quad_command_mode ? {op_sh_reg[3:0], io_s2_reg}
                                         : {op_sh_reg[6:0], io_s2_reg[0]};
  wire [3:0] op_last = quad_command_mode ? 4'h1 : 4'h7;

  // Opcode decode
  reg        dec_ok;
  reg  [3:0] dec_width;
  reg        dec_quad;
  reg        dec_wide;
  always @* begin
    dec_ok    = 1'b1;
    dec_width = 4'h1;
    dec_quad  = 1'b0;
    dec_wide  = 1'b0;
    case (op_new)
      `OP_SINGLE_DTR:      dec_width = 4'h1;
      `OP_DUAL_DTR:        dec_width = 4'h2;
      `OP_QUAD_DTR: begin
        dec_width = 4'h4;
        dec_quad  = 1'b1;
      end
      `OP_SINGLE_DTR_WIDE: dec_wide = 1'b1;
      `OP_DUAL_DTR_WIDE: begin
        dec_width = 4'h2;
        dec_wide  = 1'b1;
      end
      `OP_QUAD_DTR_WIDE: begin
        dec_width = 4'h4;
        dec_quad  = 1'b1;
        dec_wide  = 1'b1;
      end
      default: dec_ok = 1'b0;
    endcase
    // Only the quad reads exist in quad command mode; quad reads need quad enable
    if (quad_command_mode && !dec_quad) begin
      dec_ok = 1'b0;
    end
    if (dec_quad && !quad_enable_bit) begin
      dec_ok = 1'b0;
    end
  end

  // Dummy count from the two select bits
  reg [4:0] dummy_sel;
  always @* begin
    case ({dummy_select_high, dummy_select_low})
      2'b00:   dummy_sel = `DUMMY_SEL_00;
      2'b01:   dummy_sel = `DUMMY_SEL_01;
      2'b10:   dummy_sel = `DUMMY_SEL_10;
      default: dummy_sel = `DUMMY_SEL_11;
    endcase
  end

  // Address capture and assembly
  wire [31:0] addr_new  = (addr_sh_reg << width_reg) | {28'h000_0000, io_s2_reg & lane_mask(width_reg)};
  wire [5:0]  abits_new = abits_reg + {2'b00, width_reg};
  wire [31:0] addr_full = (alen_reg == `ADDR_BITS_NARROW)
                          ? {7'h00, extended_address_bit, addr_new[23:0]}
                          : addr_new;

  // Preamble clock index and bit
  wire [4:0] pre_clk  = dcnt_reg + 5'h01;
  wire [3:0] pre_idx  = 4'h9 - pre_clk[3:0];
  wire [7:0] pre_pattern = `PREAMBLE_PATTERN;
  wire       pre_bit  = pre_pattern[pre_idx[2:0]];
  wire       pre_show = preamble_enable_bit && (pre_clk >= `PREAMBLE_FIRST_CLK)
                        && (pre_clk < ndummy_reg);

  // A new byte is taken at the last dummy fall and whenever a byte is used up
  wire last_dummy = (state_reg == ST_DUMMY) && sclk_fall && (dcnt_reg == ndummy_reg - 5'h01);
  wire load_now   = last_dummy || ((state_reg == ST_DATA) && any_edge && (left_reg == 4'h0));

  // Prefetch buffer between array and shifter
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire       fifo_flush = cs_s2_reg | cs_fall;
  wire       fifo_push  = mem_valid & fetch_busy_reg & ~discard_reg;
  wire       fifo_pop   = load_now & ~cs_s2_reg;
  wire [7:0] load_byte  = fifo_out_valid ? fifo_out_data : `UNDERRUN_BYTE;

  byte_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .flush     (fifo_flush),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (mem_rdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // Lines used for a given bits-per-edge
  function [3:0] lane_mask;
    input [3:0] w;
    begin
      case (w)
        4'h1:    lane_mask = 4'b0001;
        4'h2:    lane_mask = 4'b0011;
        default: lane_mask = 4'b1111;
      endcase
    end
  endfunction

  // Output lines for a given bits-per-edge; single data leaves on line 1
  function [3:0] out_mask;
    input [3:0] w;
    begin
      out_mask = (w == 4'h1) ? 4'b0010 : lane_mask(w);
    end
  endfunction

  // Top bits of a byte placed on the output lines, MSB on the highest line
  function [3:0] map_bits;
    input [3:0] w;
    input [7:0] b;
    begin
      case (w)
        4'h1:    map_bits = {2'b00, b[7], 1'b0};
        4'h2:    map_bits = {2'b00, b[7:6]};
        default: map_bits = b[7:4];
      endcase
    end
  endfunction

  // Pin synchronisers: three flops for chip select and clock, two for the data lines
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cs_s1_reg   <= 1'b1;
      cs_s2_reg   <= 1'b1;
      cs_s3_reg   <= 1'b1;
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      io_s1_reg   <= 4'h0;
      io_s2_reg   <= 4'h0;
    end else if (clk_en) begin
      cs_s1_reg   <= cs_n_pin;
      cs_s2_reg   <= cs_s1_reg;
      cs_s3_reg   <= cs_s2_reg;
      sclk_s1_reg <= sclk_pin;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      io_s1_reg   <= io_in;
      io_s2_reg   <= io_s1_reg;
    end
  end

  // Array fetch: one request outstanding, stalled by a full buffer
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mem_req        <= 1'b0;
      mem_addr       <= 32'h0000_0000;
      fetch_busy_reg <= 1'b0;
      discard_reg    <= 1'b0;
    end else if (clk_en) begin
      mem_req <= 1'b0;
      if (mem_valid && fetch_busy_reg) begin
        fetch_busy_reg <= 1'b0;
        discard_reg    <= 1'b0;
        if (!discard_reg) begin
          mem_addr <= (mem_addr + 32'h0000_0001) & `ARRAY_ADDR_MASK;
        end
      end
      if (fifo_flush && fetch_busy_reg && !(mem_valid)) begin
        discard_reg <= 1'b1;
      end
      if (addr_edge && (abits_new == alen_reg)) begin
        mem_addr <= addr_full & `ARRAY_ADDR_MASK;
      end else if (fetch_en_reg && !fetch_busy_reg && fifo_in_ready && !fifo_flush) begin
        mem_req        <= 1'b1;
        fetch_busy_reg <= 1'b1;
      end
    end
  end

  // Command sequencer and output shifter
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= ST_IDLE;
      op_sh_reg     <= 8'h00;
      op_cnt_reg    <= 4'h0;
      width_reg     <= 4'h1;
      quad_cmd_reg  <= 1'b0;
      alen_reg      <= `ADDR_BITS_NARROW;
      abits_reg     <= 6'h00;
      addr_sh_reg   <= 32'h0000_0000;
      dcnt_reg      <= 5'h00;
      ndummy_reg    <= `DUMMY_SEL_00;
      ind_hi_reg    <= 4'h0;
      dsh_reg       <= 8'h00;
      left_reg      <= 4'h0;
      fetch_en_reg  <= 1'b0;
      io_out        <= 4'h0;
      io_oe         <= 4'h0;
      enhance_mode  <= 1'b0;
      read_active   <= 1'b0;
      read_rejected <= 1'b0;
    end else if (clk_en) begin
      if (cs_s2_reg) begin
        // Deselected: release the lines and drop the read
        state_reg    <= ST_IDLE;
        io_oe        <= 4'h0;
        fetch_en_reg <= 1'b0;
        read_active  <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (cs_fall) begin
              op_cnt_reg    <= 4'h0;
              abits_reg     <= 6'h00;
              read_rejected <= 1'b0;
              if (enhance_mode && !write_in_progress) begin
                state_reg   <= ST_ADDR;
                read_active <= 1'b1;
              end else if (enhance_mode) begin
                state_reg     <= ST_IGNORE;
                read_rejected <= 1'b1;
              end else begin
                state_reg <= ST_OPCODE;
              end
            end
          end
          ST_OPCODE: begin
            if (sclk_rise) begin
              op_sh_reg  <= op_new;
              op_cnt_reg <= op_cnt_reg + 4'h1;
              if (op_cnt_reg == op_last) begin
                if (!dec_ok) begin
                  state_reg <= ST_IGNORE;
                end else if (write_in_progress) begin
                  state_reg     <= ST_IGNORE;
                  read_rejected <= 1'b1;
                end else begin
                  state_reg    <= ST_ADDR;
                  read_active  <= 1'b1;
                  width_reg    <= dec_width;
                  quad_cmd_reg <= dec_quad;
                  alen_reg     <= (dec_wide || wide_addr_mode) ? `ADDR_BITS_WIDE
                                                               : `ADDR_BITS_NARROW;
                end
              end
            end
          end
          ST_ADDR: begin
            // Address on both edges, MSB first
            if (addr_edge) begin
              addr_sh_reg <= addr_new;
              abits_reg   <= abits_new;
              if (abits_new == alen_reg) begin
                state_reg    <= ST_DUMMY;
                dcnt_reg     <= 5'h00;
                ndummy_reg   <= dummy_sel;
                fetch_en_reg <= 1'b1;
              end
            end
          end
          ST_DUMMY: begin
            // First dummy clock of a quad read carries the enhance indicator
            if (sclk_rise && quad_cmd_reg && (dcnt_reg == 5'h00)) begin
              ind_hi_reg <= io_s2_reg;
            end
            if (sclk_fall) begin
              if (quad_cmd_reg && (dcnt_reg == 5'h00)) begin
                enhance_mode <= ((ind_hi_reg ^ io_s2_reg) == 4'hF);
              end
              if (last_dummy) begin
                state_reg <= ST_DATA;
                io_out    <= map_bits(width_reg, load_byte);
                io_oe     <= out_mask(width_reg);
                dsh_reg   <= load_byte << width_reg;
                left_reg  <= 4'h8 - width_reg;
              end else begin
                dcnt_reg <= dcnt_reg + 5'h01;
                // Preamble only after the indicator clock, trailing bits cut short
                if (pre_show) begin
                  io_out <= {4{pre_bit}} & out_mask(width_reg);
                  io_oe  <= out_mask(width_reg);
                end else begin
                  io_oe <= 4'h0;
                end
              end
            end
          end
          ST_DATA: begin
            // New bits on every edge; rising-edge bits precede falling-edge bits
            if (any_edge) begin
              if (left_reg == 4'h0) begin
                io_out   <= map_bits(width_reg, load_byte);
                dsh_reg  <= load_byte << width_reg;
                left_reg <= 4'h8 - width_reg;
              end else begin
                io_out   <= map_bits(width_reg, dsh_reg);
                dsh_reg  <= dsh_reg << width_reg;
                left_reg <= left_reg - width_reg;
              end
            end
          end
          ST_IGNORE: begin
            io_oe <= 4'h0;
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // dtr_read_preamble_addr4
`default_nettype wire

// [src/dtr_read_consts.vh]
// Constants for the double-rate read path: opcodes, dummy counts, preamble, array size
`ifndef DTR_READ_CONSTS_VH
`define DTR_READ_CONSTS_VH

// Opcodes, three-byte or mode-dependent address
`define OP_SINGLE_DTR      8'h0D
`define OP_DUAL_DTR        8'hBD
`define OP_QUAD_DTR        8'hED
// Opcodes that always take a 32-bit address
`define OP_SINGLE_DTR_WIDE 8'h0E
`define OP_DUAL_DTR_WIDE   8'hBE
`define OP_QUAD_DTR_WIDE   8'hEE

// Address lengths in bits
`define ADDR_BITS_NARROW   6'h18
`define ADDR_BITS_WIDE     6'h20

// Dummy clocks for each setting of {dummy_select_high, dummy_select_low}
`define DUMMY_SEL_00       5'h06
`define DUMMY_SEL_01       5'h08
`define DUMMY_SEL_10       5'h0A
`define DUMMY_SEL_11       5'h04

// Preamble training pattern and the clock where it starts
`define PREAMBLE_PATTERN   8'h34
`define PREAMBLE_FIRST_CLK 5'h02

// Array address mask (top address, wrap to zero beyond it)
`define ARRAY_ADDR_MASK    32'h03FF_FFFF

// Byte shown when the prefetch buffer has run dry
`define UNDERRUN_BYTE      8'hFF

// Prefetch buffer shape
`define FIFO_WIDTH         8
`define FIFO_DEPTH         32
`define FIFO_AW            5

`endif

// [src/byte_fifo.v]
// Synchronous FIFO with valid/ready on both sides and a flush
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock, reset, enable
  input  wire             mclk,
  input  wire             reset_n,
  input  wire             clk_en,
  input  wire             flush,
  // Filling side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Draining side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;

  wire do_push;
  wire do_pop;

  // Honest full and empty from the occupancy count
  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = store[rd_ptr_reg];
  assign do_push   = in_valid & in_ready;
  assign do_pop    = out_valid & out_ready;

  // Storage array, written only on an accepted push
  always @(posedge mclk) begin
    if (clk_en && do_push && !flush) begin
      store[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and count
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else if (clk_en) begin
      if (flush) begin
        wr_ptr_reg <= {AW{1'b0}};
        rd_ptr_reg <= {AW{1'b0}};
        count_reg  <= {(AW+1){1'b0}};
      end else begin
        if (do_push) begin
          wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
        end
        if (do_pop) begin
          rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
        end
        if (do_push && !do_pop) begin
          count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
        end else if (do_pop && !do_push) begin
          count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // byte_fifo
`default_nettype wire

// [test/dtr_read_checker_properties.sv]
// Port-level assertions for the double-rate read path
`timescale 1ns/1ns
`default_nettype none
`include "dtr_read_consts.vh"
module dtr_read_checker (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset_n,
  // Serial side
  input wire logic        cs_n_pin,
  input wire logic [3:0]  io_oe,
  // Status and configuration
  input wire logic        write_in_progress,
  input wire logic        quad_enable_bit,
  input wire logic        enhance_mode,
  input wire logic        read_active,
  input wire logic        read_rejected,
  // Array port
  input wire logic        mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_valid
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // Deselected device leaves every line to the host
  a_idle_undriven: assert property (cs_n_pin [*8] |-> io_oe == 4'h0)
    else $error("lines driven while deselected");
  // Enables stay put while the frame lasts
  a_oe_held: assert property ((!cs_n_pin) [*8] ##0 (io_oe != 4'h0) |=> $stable(io_oe))
    else $error("line enables moved inside a frame");
  // A busy write cycle never lets a read start
  a_busy_refused: assert property (write_in_progress [*3] |-> !$rose(read_active))
    else $error("read started during write cycle");
  a_rejected_quiet: assert property (read_rejected |-> io_oe == 4'h0 && !read_active)
    else $error("refused read drives lines");
  // Only one, two or four lane groups are ever driven
  a_oe_lanes: assert property (io_oe == 4'h0 || io_oe == 4'h2 || io_oe == 4'h3 || io_oe == 4'hF)
    else $error("illegal lane enable pattern");
  a_quad_gated: assert property (io_oe == 4'hF |-> quad_enable_bit)
    else $error("quad lanes driven without quad enable");
  // Array address steps by one per answer and wraps at the top
  a_addr_step: assert property (mem_valid && read_active && !cs_n_pin
    |=> mem_addr == (($past(mem_addr) + 32'h0000_0001) & `ARRAY_ADDR_MASK))
    else $error("array address did not advance");
  a_req_masked: assert property (mem_req |-> (mem_addr & ~`ARRAY_ADDR_MASK) == 32'h0000_0000)
    else $error("array request beyond top address");
  a_enhance_framed: assert property ($changed(enhance_mode) |-> !cs_n_pin && quad_enable_bit)
    else $error("enhance mode changed outside a quad frame");

  // Main scenarios reached
  c_quad_data: cover property (read_active && io_oe == 4'hF);
  c_enhance: cover property ($rose(enhance_mode));
  c_rejected: cover property ($rose(read_rejected));
endmodule // dtr_read_checker
`default_nettype wire

// [test/flash_host_model.sv]
// Host controller model driving chip select, serial clock and data lines
`timescale 1ns/1ns
`default_nettype none
module flash_host_model (
  // Serial pins toward the device
  output logic            cs_n_pin,
  output logic            sclk_pin,
  output logic [3:0]      io_in,
  // Device lines and their enables
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe
);
  logic [7:0] got[$]; // Enables and data seen just before each clock edge

  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    io_in    = 4'h0;
  end

  // Half period of 62 or 63 ns: set lines mid-phase, record device lines, toggle clock
  task automatic half(input logic [3:0] d);
    #31 io_in = d;
    #(31 + sclk_pin) got.push_back({io_oe, io_out});
    sclk_pin = ~sclk_pin;
  endtask

  // One frame: opcode, address, indicator, dummies, data; clock stands still outside it
  task automatic frame(input logic [7:0] op, input logic [31:0] a, input int ab, input int ln, input int oc,
                       input int nd, input int nb, input logic [7:0] ind);
    int e;
    int pd;
    logic [3:0] d;
    begin
      got.delete();
      pd = 2 * oc + ab / ln;
      cs_n_pin = 1'b0;
      for (e = 0; e < pd + 2 * nd + nb * 8 / ln; e++) begin
        if (e < 2 * oc)
          d = (oc == 2) ? (e < 2 ? op[7:4] : op[3:0]) : {~io_in[3:1], op[7 - e / 2]};
        else if (e < pd)
          d = 4'((a << (32 - ab + (e - 2 * oc) * ln)) >> (32 - ln));
        else if (e < pd + 2 && ln == 4)
          d = (e == pd) ? ind[7:4] : ind[3:0];
        else
          d = ~io_in; // Released lines keep toggling
        if (e >= pd + 2 * nd && $urandom % 8 == 0)
          #50; // Stall the clock mid-burst
        half(d);
      end
      #40 cs_n_pin = 1'b1;
      io_in = ~io_in;
      #1000;
    end
  endtask
endmodule // flash_host_model
`default_nettype wire

// [test/tb_dtr_read_preamble_addr4.sv]
// Self-checking bench for the double-rate read path
`timescale 1ns/1ns
`default_nettype none
`include "dtr_read_consts.vh"
module tb_dtr_read_preamble_addr4;
  // Clock, reset and configuration
  logic        mclk;
  logic        reset_n = 1'b0;
  logic        write_in_progress = 1'b0;
  logic        quad_enable_bit = 1'b1;
  logic        quad_command_mode = 1'b0;
  logic        wide_addr_mode = 1'b0;
  logic        extended_address_bit = 1'b0;
  logic        dummy_select_low = 1'b0;
  logic        dummy_select_high = 1'b0;
  logic        preamble_enable_bit = 1'b0;
  // Pins, status and array port
  wire         cs_n_pin;
  wire         sclk_pin;
  wire  [3:0]  io_in;
  wire  [3:0]  io_out;
  wire  [3:0]  io_oe;
  wire         enhance_mode;
  wire         read_active;
  wire         read_rejected;
  wire         mem_req;
  wire  [31:0] mem_addr;
  logic        mem_valid = 1'b0;
  logic [7:0]  mem_rdata = 8'h00;
  logic        slow = 1'b0;
  logic [31:0] pend[$];
  logic [7:0]  ops[6] = '{`OP_SINGLE_DTR, `OP_DUAL_DTR, `OP_QUAD_DTR,
                          `OP_SINGLE_DTR_WIDE, `OP_DUAL_DTR_WIDE, `OP_QUAD_DTR_WIDE};
  int          fail_count = 0;
  int          cmp_count = 0;
  int          i;
  int          x;

  dtr_read_preamble_addr4 u_dtr_read_preamble_addr4 (
    .mclk, .reset_n, .clk_en(1'b1), .cs_n_pin, .sclk_pin, .io_in, .io_out, .io_oe, .write_in_progress,
    .quad_enable_bit, .quad_command_mode, .wide_addr_mode, .extended_address_bit, .dummy_select_low,
    .dummy_select_high, .preamble_enable_bit, .enhance_mode, .read_active, .read_rejected, .mem_req,
    .mem_addr, .mem_valid, .mem_rdata);
  flash_host_model u_flash_host_model (.cs_n_pin, .sclk_pin, .io_in, .io_out, .io_oe);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Array contents as a function of address
  function automatic logic [7:0] fdat(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24] ^ 8'h5A;
  endfunction

  function automatic int dummies(input logic [1:0] s);
    return int'((s == 2'b00) ? `DUMMY_SEL_00 : (s == 2'b01) ? `DUMMY_SEL_01 : (s == 2'b10) ? `DUMMY_SEL_10 : `DUMMY_SEL_11);
  endfunction

  // Array model: answers each request in order, on every other cycle
  always @(negedge mclk) begin
    slow <= ~slow;
    mem_valid <= 1'b0;
    if (mem_req)
      pend.push_back(mem_addr);
    if (pend.size() > 0 && slow) begin
      mem_valid <= 1'b1;
      mem_rdata <= fdat(pend.pop_front());
    end
  end

  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One read frame with its expected preamble, data and enhance state
  task automatic rd(input int k, input logic [31:0] a, input int nb, input logic [1:0] sel, input logic pre,
                    input logic [7:0] ind, input int oc);
    int ln, ab, nd, pd, g;
    logic [3:0] lm;
    logic [7:0] b, s;
    logic [31:0] st;
    begin
      @(negedge mclk);
      {dummy_select_high, dummy_select_low} = sel;
      preamble_enable_bit = pre;
      quad_command_mode = (oc == 2);
      ln = (k % 3 == 0) ? 1 : (k % 3 == 1) ? 2 : 4;
      ab = (k >= 3 || wide_addr_mode) ? 32 : 24;
      nd = dummies(sel);
      lm = (ln == 1) ? 4'h2 : (ln == 2) ? 4'h3 : 4'hF;
      st = (ab == 32) ? a : {7'h00, extended_address_bit, a[23:0]};
      u_flash_host_model.frame(ops[k], a, ab, ln, oc, nd, nb, ind);
      pd = 2 * oc + ab / ln;
      for (g = 2; g < nd; g++) begin
        b = `PREAMBLE_PATTERN >> (9 - g);
        s = u_flash_host_model.got[pd + 2 * g + 1] & {lm, pre ? lm : 4'h0};
        chk("preamble", s, pre ? {lm, b[0] ? lm : 4'h0} : 8'h00);
      end
      for (g = 0; g < nb * 8 / ln; g++) begin
        b = fdat((st + 32'(g / (8 / ln))) & `ARRAY_ADDR_MASK) >> (8 - ln * (g % (8 / ln) + 1));
        s = u_flash_host_model.got[pd + 2 * nd + g] & {lm, lm};
        chk("data", s, {lm, lm & (ln == 1 ? {2'b00, b[0], 1'b0} : b[3:0])});
      end
      chk("enhance", 8'(enhance_mode), 8'(ln == 4 && ind[7:4] == ~ind[3:0]));
      $display("read %h at %h done", ops[k], a);
    end
  endtask

  // A refused frame never drives a line
  task automatic quiet();
    logic [3:0] o;
    begin
      o = 4'h0;
      foreach (u_flash_host_model.got[j])
        o = o | u_flash_host_model.got[j][7:4];
      chk("refused lines", 8'(o), 8'h00);
      chk("idle", 8'(read_active), 8'h00);
      $display("refused frame done");
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h0000_0c6d));
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    // Corners: extended address bit, wrap at the top, long quad burst past the buffer depth
    @(negedge mclk) extended_address_bit = 1'b1;
    rd(0, 32'h00FF_FFFE, 3, 2'b00, 1'b1, 8'h00, 8);
    @(negedge mclk) extended_address_bit = 1'b0;
    rd(3, 32'h03FF_FFFE, 4, 2'b11, 1'b1, 8'h00, 8);
    rd(2, 32'h0012_3400, 40, 2'b10, 1'b1, 8'h00, 2);
    // All six commands and widths in turn, random dummy settings and address modes
    for (i = 0; i < 12; i++) begin
      @(negedge mclk) wide_addr_mode = 1'($urandom);
      x = $urandom % 16;
      rd(i % 6, $urandom, 1 + $urandom % 4, 2'($urandom), 1'($urandom), {4'(x), 4'(x)}, (i % 3 == 2 && x[0]) ? 2 : 8);
    end
    // Enhance mode entered, then a frame without opcode leaves it
    @(negedge mclk) wide_addr_mode = 1'b0;
    rd(5, 32'h0123_4567, 2, 2'b00, 1'b0, 8'hA5, 8);
    rd(5, 32'h0012_3450, 2, 2'b01, 1'b1, 8'hFF, 0);
    // Refusals: busy write cycle, quad read without quad enable
    @(negedge mclk) write_in_progress = 1'b1;
    u_flash_host_model.frame(ops[0], 32'h0000_0100, 24, 1, 8, 6, 2, 8'h00);
    chk("rejected", 8'(read_rejected), 8'h01);
    quiet();
    @(negedge mclk) write_in_progress = 1'b0;
    quad_enable_bit = 1'b0;
    u_flash_host_model.frame(ops[2], 32'h0000_0100, 24, 4, 8, 6, 2, 8'h00);
    quiet();
    conclude();
  end

  // Watchdog against a hung run
  initial begin
    #500_000;
    fail_count++;
    conclude();
  end
endmodule // tb_dtr_read_preamble_addr4

bind dtr_read_preamble_addr4 dtr_read_checker u_dtr_read_checker (
  .mclk, .reset_n, .cs_n_pin, .io_oe, .write_in_progress, .quad_enable_bit, .enhance_mode,
  .read_active, .read_rejected, .mem_req, .mem_addr, .mem_valid);
`default_nettype wire
